// ---- core/sfa_pkg.sv ----
// Shared constants for the auxiliary flash command block and its host.
// Assumes a 20 MHz system clock on both ends of the serial link.
package sfa_pkg;
    localparam int unsigned CLK_NS = 50;
    // Opcodes
    localparam logic [7:0] OP_SEC_RD = 8'h77;
    localparam logic [7:0] OP_XFER_B1 = 8'h53;
    localparam logic [7:0] OP_XFER_B2 = 8'h55;
    localparam logic [7:0] OP_CMP_B1 = 8'h60;
    localparam logic [7:0] OP_CMP_B2 = 8'h61;
    localparam logic [7:0] OP_RW_B1 = 8'h58;
    localparam logic [7:0] OP_RW_B2 = 8'h59;
    localparam logic [7:0] OP_STAT = 8'hD7;
    // Frame layout in bits; security register size in bytes
    localparam logic [10:0] OPC_BITS = 11'h008;
    localparam logic [10:0] HDR_BITS = 11'h020;
    localparam logic [10:0] CNT_MAX = 11'h7FF;
    localparam logic [7:0] SEC_BYTES = 8'h80;
    // Status byte fields
    localparam int unsigned ST_RDY = 7;
    localparam int unsigned ST_COMP = 6;
    localparam int unsigned ST_P512 = 0;
    // Density code value is arbitrary
    localparam logic [3:0] DENSITY = 4'h0;
    // Internal operation times, longest values in ns
    localparam int unsigned PAGE_TRANSFER_TIME_NS = 200000;
    localparam int unsigned COMPARE_TIME_NS = 200000;
    localparam int unsigned ERASE_PROGRAM_TIME_NS = 35000000;
    localparam int unsigned XFR_CYC = PAGE_TRANSFER_TIME_NS / CLK_NS;
    localparam int unsigned CMP_CYC = COMPARE_TIME_NS / CLK_NS;
    localparam int unsigned EP_CYC = ERASE_PROGRAM_TIME_NS / CLK_NS;
    // Host link timing: half period of the serial clock, gap with select high
    localparam logic [4:0] SCK_HALF = 5'h0A;
    localparam logic [7:0] CS_GAP = 8'h14;
    // Array operation codes towards the memory model
    typedef enum logic [1:0] {
        ARR_XFER = 2'b00,
        ARR_CMP = 2'b01,
        ARR_REWRITE = 2'b10,
        ARR_RMW = 2'b11
    } sfa_arr_op_t;
    // Page index from the 24 address bits
    function automatic logic [11:0] page_of(input logic [23:0] a, input logic p512);
        page_of = p512 ? a[20:9] : a[21:10];
    endfunction
    // 24 address bits from a page index
    function automatic logic [23:0] addr_of(input logic [11:0] p, input logic p512);
        addr_of = p512 ? {3'h0, p, 9'h000} : {2'h0, p, 10'h000};
    endfunction
endpackage

// ---- core/sfa_if.sv ----
// Serial link between the flash command block and its host.
// The data-out line idles high through a pull-up when nobody drives it.
`timescale 1ns/1ps
interface sfa_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so_out;
    logic so_oe;
    wire so_line = so_oe ? so_out : 1'b1;

    modport dev (
        input cs_n,
        input sck,
        input si,
        output so_out,
        output so_oe
    );
    modport host (
        output cs_n,
        output sck,
        output si,
        input so_line
    );
endinterface

// ---- core/sfa_dev.sv ----
// Flash-side command handling: security read, page transfer, compare, rewrite.
// Assumes link pins arrive unsynchronised; array behaviour is modelled outside.
`timescale 1ns/1ps
// Functional notes
// - Fixed read-only 128-byte security register
// - 77h plus three dummies, then bytes
// - Data past byte 127 is undefined
// - Select high ends read, releases output
// - 53h/55h transfer page to buffer 1/2
// - 528 mode: two dummies, page, ten dummies
// - 512 mode: three dummies, page, nine dummies
// - Select low for header; start on rise
// - Busy during transfer, ready when done
// - 60h/61h compare page with buffer 1/2
// - Compare starts on select rise, busy
// - Compare result written to status bit 6
// - Flag 1 on mismatch, 0 on match
// - 58h/59h auto rewrite, no data bytes
// - Rewrite copies page, reprograms it, busy
// - Data after rewrite header means modify-write
// - Host refreshes pages within 50,000 cycles; sfa_host issues no refresh rewrites
// - D7h status, bit 7 is ready
// - Status bit 0 shows 512-byte mode
module sfa_dev #(
    parameter int unsigned XFR_CYCLES = sfa_pkg::XFR_CYC,
    parameter int unsigned CMP_CYCLES = sfa_pkg::CMP_CYC,
    parameter int unsigned EP_CYCLES = sfa_pkg::EP_CYC
) (
    input wire logic clk_sys,
    input wire logic resetn,
    sfa_if.dev spi,
    input wire logic page_size_512,
    input wire logic arr_mismatch,
    output logic arr_req,
    output sfa_pkg::sfa_arr_op_t arr_op,
    output logic [11:0] arr_page,
    output logic arr_buf2,
    output logic busy
);
    // Arbitrary per-device contents; no path writes them
    function automatic logic [7:0] sec_byte(input logic [6:0] i);
        sec_byte = 8'({1'b0, i} * 8'h3B) ^ 8'hA5;
    endfunction

    logic sck_m_ff, sck_s_ff, sck_d_ff;
    logic cs_m_ff, cs_s_ff, cs_d_ff;
    logic si_m_ff, si_s_ff;
    logic [10:0] bitcnt_ff;
    logic [7:0] op_ff;
    logic [23:0] addr_ff;
    logic so_ff, so_oe_ff;
    logic busy_ff, comp_ff, mode_ff, req_ff, buf2_ff;
    sfa_pkg::sfa_arr_op_t aop_ff;
    logic [11:0] page_ff;
    logic [23:0] timer_ff;

    // Two stages on every pin before any logic looks at it
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sck_m_ff <= 1'b0;
            sck_s_ff <= 1'b0;
            sck_d_ff <= 1'b0;
            cs_m_ff <= 1'b1;
            cs_s_ff <= 1'b1;
            cs_d_ff <= 1'b1;
            si_m_ff <= 1'b0;
            si_s_ff <= 1'b0;
        end else begin
            sck_m_ff <= spi.sck;
            sck_s_ff <= sck_m_ff;
            sck_d_ff <= sck_s_ff;
            cs_m_ff <= spi.cs_n;
            cs_s_ff <= cs_m_ff;
            cs_d_ff <= cs_s_ff;
            si_m_ff <= spi.si;
            si_s_ff <= si_m_ff;
        end
    end

    wire sck_rise = sck_s_ff & ~sck_d_ff & ~cs_s_ff;
    wire sck_fall = ~sck_s_ff & sck_d_ff & ~cs_s_ff;
    wire cs_rise = cs_s_ff & ~cs_d_ff;

    // Header capture; counter saturates so long reads never wrap back to byte 0
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bitcnt_ff <= 11'h000;
            op_ff <= 8'h00;
            addr_ff <= 24'h000000;
        end else if (cs_rise) begin
            bitcnt_ff <= 11'h000;
        end else if (sck_rise) begin
            if (bitcnt_ff < sfa_pkg::OPC_BITS) begin
                op_ff <= {op_ff[6:0], si_s_ff};
            end else if (bitcnt_ff < sfa_pkg::HDR_BITS) begin
                addr_ff <= {addr_ff[22:0], si_s_ff};
            end
            if (bitcnt_ff != sfa_pkg::CNT_MAX) begin
                bitcnt_ff <= bitcnt_ff + 11'h001;
            end
        end
    end

    // Output selection
    wire is_sec = op_ff == sfa_pkg::OP_SEC_RD;
    wire is_stat = op_ff == sfa_pkg::OP_STAT;
    wire sec_out = is_sec & (bitcnt_ff >= sfa_pkg::HDR_BITS);
    wire stat_out = is_stat & (bitcnt_ff >= sfa_pkg::OPC_BITS);
    wire [10:0] sec_pos = bitcnt_ff - sfa_pkg::HDR_BITS;
    wire [10:0] stat_pos = bitcnt_ff - sfa_pkg::OPC_BITS;
    wire sec_in_range = sec_pos[10:3] < sfa_pkg::SEC_BYTES;
    wire [7:0] sec_b = sec_byte(sec_pos[9:3]);
    wire [7:0] stat1 = {~busy_ff, comp_ff, sfa_pkg::DENSITY, 1'b0, mode_ff};
    wire [7:0] stat2 = {~busy_ff, 7'h00};
    wire [7:0] stat_b = stat_pos[3] ? stat2 : stat1;
    // Beyond the last byte the line just reads low
    wire sec_bit = sec_in_range & sec_b[~sec_pos[2:0]];
    wire stat_bit = stat_b[~stat_pos[2:0]];

    // Data changes on the falling serial edge, mode 0 style
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            so_ff <= 1'b0;
            so_oe_ff <= 1'b0;
        end else if (cs_s_ff) begin
            so_oe_ff <= 1'b0;
        end else if (sck_fall) begin
            so_ff <= sec_out ? sec_bit : stat_bit;
            so_oe_ff <= sec_out | stat_out;
        end
    end

    // Command decode at select release
    wire op_xfer = (op_ff == sfa_pkg::OP_XFER_B1) | (op_ff == sfa_pkg::OP_XFER_B2);
    wire op_cmp = (op_ff == sfa_pkg::OP_CMP_B1) | (op_ff == sfa_pkg::OP_CMP_B2);
    wire op_rw = (op_ff == sfa_pkg::OP_RW_B1) | (op_ff == sfa_pkg::OP_RW_B2);
    wire op_b2 = (op_ff == sfa_pkg::OP_XFER_B2) | (op_ff == sfa_pkg::OP_CMP_B2)
        | (op_ff == sfa_pkg::OP_RW_B2);
    wire hdr_exact = bitcnt_ff == sfa_pkg::HDR_BITS;
    // Partial bytes after the header abort the command
    wire rmw_frame = op_rw & (bitcnt_ff > sfa_pkg::HDR_BITS) & (bitcnt_ff[2:0] == 3'h0);
    wire start = cs_rise & ~busy_ff & (((op_xfer | op_cmp | op_rw) & hdr_exact) | rmw_frame);
    wire [11:0] page_sel = sfa_pkg::page_of(addr_ff, mode_ff);
    sfa_pkg::sfa_arr_op_t nxt_aop;
    logic [23:0] nxt_time;
    assign nxt_aop = rmw_frame ? sfa_pkg::ARR_RMW
        : op_rw ? sfa_pkg::ARR_REWRITE
        : op_cmp ? sfa_pkg::ARR_CMP : sfa_pkg::ARR_XFER;
    // Rewrite covers the copy plus erase and program
    assign nxt_time = op_rw ? 24'(XFR_CYCLES + EP_CYCLES)
        : op_cmp ? 24'(CMP_CYCLES) : 24'(XFR_CYCLES);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_ff <= 1'b1;
        end else begin
            mode_ff <= page_size_512;
        end
    end

    // Busy timing and the compare flag
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            busy_ff <= 1'b0;
            timer_ff <= 24'h000000;
            comp_ff <= 1'b0;
            req_ff <= 1'b0;
            aop_ff <= sfa_pkg::ARR_XFER;
            page_ff <= 12'h000;
            buf2_ff <= 1'b0;
        end else begin
            req_ff <= start;
            if (start) begin
                busy_ff <= 1'b1;
                timer_ff <= nxt_time;
                aop_ff <= nxt_aop;
                page_ff <= page_sel;
                buf2_ff <= op_b2;
            end else if (busy_ff) begin
                timer_ff <= timer_ff - 24'h000001;
                if (timer_ff <= 24'h000001) begin
                    busy_ff <= 1'b0;
                    if (aop_ff == sfa_pkg::ARR_CMP) begin
                        comp_ff <= arr_mismatch;
                    end
                end
            end
        end
    end

    assign spi.so_out = so_ff;
    assign spi.so_oe = so_oe_ff;
    assign arr_req = req_ff;
    assign arr_op = aop_ff;
    assign arr_page = page_ff;
    assign arr_buf2 = buf2_ff;
    assign busy = busy_ff;
endmodule

// ---- core/sfa_host.sv ----
// Host end: queued commands, ready polling, header send, security readback.
// Assumes the far end samples on rising and drives on falling serial edges.
`timescale 1ns/1ps
module sfa_fifo #(
    parameter int unsigned W = 20,
    parameter int unsigned D = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_ff, rp_ff;
    logic [AW:0] cnt_ff;
    logic rdy_ff;
    wire push = in_valid & rdy_ff;
    wire pop = out_ready & (cnt_ff != '0);
    wire [AW:0] nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wp_ff] <= in_data;
        end
    end
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
        end else begin
            wp_ff <= push ? AW'(wp_ff + 1'b1) : wp_ff;
            rp_ff <= pop ? AW'(rp_ff + 1'b1) : rp_ff;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_cnt != (AW + 1)'(D);
        end
    end
    assign in_ready = rdy_ff;
    assign out_valid = cnt_ff != '0;
    assign out_data = mem[rp_ff];
endmodule

module sfa_host (
    input wire logic clk_sys,
    input wire logic resetn,
    sfa_if.host spi,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [19:0] cmd_data,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic [7:0] status,
    output logic busy
);
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_POLL = 3'b001,
        H_PGAP = 3'b010,
        H_CMD = 3'b011,
        H_CGAP = 3'b100
    } sfa_hst_t;

    sfa_hst_t st_ff;
    logic [19:0] cmd_ff;
    logic [31:0] tx_ff;
    logic [5:0] txn_ff;
    logic [7:0] rxn_ff, rx_ff, gap_ff, status_ff, rd_data_ff;
    logic [2:0] rxbit_ff;
    logic [4:0] div_ff;
    logic run_ff, end_ff, sck_ff, cs_n_ff, si_ff, rxpar_ff, rd_valid_ff, busy_ff;
    logic so_m_ff, so_s_ff;
    logic q_valid;
    logic [19:0] q_data;
    wire q_take = (st_ff == H_IDLE) & q_valid;

    // Commands queue here; a full queue stalls the source
    sfa_fifo #(.W(20), .D(8)) u_q (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(cmd_valid),
        .in_ready(cmd_ready),
        .in_data(cmd_data),
        .out_valid(q_valid),
        .out_ready(q_take),
        .out_data(q_data)
    );

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            so_m_ff <= 1'b1;
            so_s_ff <= 1'b1;
        end else begin
            so_m_ff <= spi.so_line;
            so_s_ff <= so_m_ff;
        end
    end

    wire tick = run_ff & (div_ff == sfa_pkg::SCK_HALF - 5'h01);
    wire rise = tick & ~sck_ff;
    wire fall = tick & sck_ff;
    wire [7:0] rx_byte = {rx_ff[6:0], so_s_ff};
    wire byte_done = rise & (txn_ff == 6'h00) & (rxbit_ff == 3'h7);
    // Stop polling only on a first status byte that shows ready
    wire poll_done = byte_done & (st_ff == H_POLL) & ~rxpar_ff & rx_byte[sfa_pkg::ST_RDY];
    wire cmd_last = rise & (st_ff == H_CMD) & (((txn_ff == 6'h01) & (rxn_ff == 8'h00))
        | (byte_done & (rxn_ff == 8'h01)));
    wire [7:0] cop = cmd_ff[19:12];
    wire is_sec = cop == sfa_pkg::OP_SEC_RD;
    wire [23:0] hdr_addr = is_sec ? 24'h000000
        : sfa_pkg::addr_of(cmd_ff[11:0], status_ff[sfa_pkg::ST_P512]);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            div_ff <= 5'h00;
            sck_ff <= 1'b0;
        end else begin
            div_ff <= (!run_ff || tick) ? 5'h00 : div_ff + 5'h01;
            sck_ff <= tick ? ~sck_ff : sck_ff;
        end
    end

    // Bit engine and sequencing
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_ff <= H_IDLE;
            cmd_ff <= 20'h00000;
            tx_ff <= 32'h00000000;
            txn_ff <= 6'h00;
            rxn_ff <= 8'h00;
            rx_ff <= 8'h00;
            rxbit_ff <= 3'h0;
            rxpar_ff <= 1'b0;
            gap_ff <= 8'h00;
            run_ff <= 1'b0;
            end_ff <= 1'b0;
            cs_n_ff <= 1'b1;
            si_ff <= 1'b0;
            status_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
            rd_data_ff <= 8'h00;
            busy_ff <= 1'b0;
        end else begin
            rd_valid_ff <= 1'b0;
            // Counts the pop as busy so queued commands show no idle gap
            busy_ff <= q_take | (st_ff != H_IDLE);
            if (gap_ff != 8'h00) begin
                gap_ff <= gap_ff - 8'h01;
            end
            if (q_take) begin
                // Status poll first, so no command hits a busy device
                cmd_ff <= q_data;
                tx_ff <= {sfa_pkg::OP_STAT, 24'h000000};
                si_ff <= sfa_pkg::OP_STAT[7];
                txn_ff <= 6'h08;
                rxbit_ff <= 3'h0;
                rxpar_ff <= 1'b0;
                cs_n_ff <= 1'b0;
                run_ff <= 1'b1;
                st_ff <= H_POLL;
            end else if ((st_ff == H_PGAP) && (gap_ff == 8'h00)) begin
                if (cop == sfa_pkg::OP_STAT) begin
                    st_ff <= H_IDLE;
                end else begin
                    tx_ff <= {cop, hdr_addr};
                    si_ff <= cop[7];
                    txn_ff <= 6'h20;
                    rxn_ff <= is_sec ? sfa_pkg::SEC_BYTES : 8'h00;
                    rxbit_ff <= 3'h0;
                    cs_n_ff <= 1'b0;
                    run_ff <= 1'b1;
                    st_ff <= H_CMD;
                end
            end else if ((st_ff == H_CGAP) && (gap_ff == 8'h00)) begin
                st_ff <= H_IDLE;
            end
            if (rise) begin
                if (txn_ff != 6'h00) begin
                    txn_ff <= txn_ff - 6'h01;
                    tx_ff <= {tx_ff[30:0], 1'b0};
                end else begin
                    rx_ff <= rx_byte;
                    rxbit_ff <= rxbit_ff + 3'h1;
                end
                if (byte_done) begin
                    rxpar_ff <= ~rxpar_ff;
                    if (st_ff == H_POLL && !rxpar_ff) begin
                        status_ff <= rx_byte;
                    end
                    if (st_ff == H_CMD) begin
                        rd_valid_ff <= 1'b1;
                        rd_data_ff <= rx_byte;
                        rxn_ff <= rxn_ff - 8'h01;
                    end
                end
                if (poll_done || cmd_last) begin
                    end_ff <= 1'b1;
                end
            end
            if (fall) begin
                si_ff <= tx_ff[31];
                if (end_ff) begin
                    // Header ends on a byte boundary; select rise starts the operation
                    end_ff <= 1'b0;
                    run_ff <= 1'b0;
                    cs_n_ff <= 1'b1;
                    gap_ff <= sfa_pkg::CS_GAP;
                    st_ff <= (st_ff == H_POLL) ? H_PGAP : H_CGAP;
                end
            end
        end
    end

    assign spi.cs_n = cs_n_ff;
    assign spi.sck = sck_ff;
    assign spi.si = si_ff;
    assign rd_valid = rd_valid_ff;
    assign rd_data = rd_data_ff;
    assign status = status_ff;
    assign busy = busy_ff;
endmodule

// ---- tb/sfa_properties.sv ----
// Link checker: framing, serial clock shape, output release, security data on the wire.
// Assumes the host sends whole headers and always reads the full security register.
`timescale 1ns/1ps
module sfa_properties (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic so_line
);
    logic sck_ff;
    logic rise_ff;
    logic [10:0] cnt_ff;
    logic [7:0] sh_ff;
    logic [7:0] rx_ff;
    logic [7:0] op_ff;
    // Edges are found on the system clock, so a rise is seen one cycle late
    wire rise = sck & ~sck_ff & ~cs_n;
    wire [10:0] nxt_cnt = cs_n ? 11'h000 : cnt_ff + {10'h000, rise};
    wire [7:0] nxt_sh = rise ? {sh_ff[6:0], si} : sh_ff;
    wire [7:0] nxt_rx = rise ? {rx_ff[6:0], so_line} : rx_ff;
    wire [7:0] nxt_op = (rise && cnt_ff == 11'h007) ? {sh_ff[6:0], si} : op_ff;
    wire [10:0] sec_idx = (cnt_ff - 11'h028) >> 3;
    wire [7:0] sec_exp = (sec_idx[7:0] * 8'h3B) ^ 8'hA5;
    wire is_cmd = op_ff inside {sfa_pkg::OP_XFER_B1, sfa_pkg::OP_XFER_B2, sfa_pkg::OP_CMP_B1,
                                sfa_pkg::OP_CMP_B2, sfa_pkg::OP_RW_B1, sfa_pkg::OP_RW_B2};

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sck_ff <= 1'b0;
            rise_ff <= 1'b0;
            cnt_ff <= 11'h000;
            sh_ff <= 8'h00;
            rx_ff <= 8'h00;
            op_ff <= 8'h00;
        end else begin
            sck_ff <= sck;
            rise_ff <= rise;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            rx_ff <= nxt_rx;
            op_ff <= nxt_op;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);

    sequence s_sel_idle;
        cs_n [*6];
    endsequence
    sequence s_frame_end;
        $rose(cs_n);
    endsequence

    a_sel_release: assert property (s_sel_idle |-> !so_oe)
        else $error("data output still driven after select rose");
    a_opc_quiet: assert property (!cs_n && (cnt_ff < 11'h008 ||
        (op_ff == sfa_pkg::OP_SEC_RD && cnt_ff < 11'h020)) |-> !so_oe)
        else $error("data output driven before the header ended");
    a_sec_drive: assert property (!cs_n && op_ff == sfa_pkg::OP_SEC_RD &&
        cnt_ff > 11'h020 |-> so_oe)
        else $error("security bytes not driven");
    a_sec_data: assert property (rise_ff && op_ff == sfa_pkg::OP_SEC_RD &&
        cnt_ff > 11'h020 && cnt_ff[2:0] == 3'h0 |-> rx_ff == sec_exp)
        else $error("security byte value wrong on the wire");
    a_hdr_len: assert property (s_frame_end |-> !is_cmd || cnt_ff == 11'h020)
        else $error("command frame not exactly opcode and three address bytes");
    a_sec_len: assert property ($rose(cs_n) && op_ff == sfa_pkg::OP_SEC_RD |->
        cnt_ff == 11'h420)
        else $error("security read frame length wrong");
    a_idle_clock: assert property (cs_n |-> !sck)
        else $error("serial clock high while deselected");
    a_sck_high: assert property ($rose(sck) |-> sck [*8])
        else $error("serial clock high phase too short");
    a_sck_low: assert property ($fell(sck) |-> !sck [*8])
        else $error("serial clock low phase too short");
    a_sel_gap: assert property (s_frame_end |-> cs_n [*8])
        else $error("select gap between frames too short");
endmodule

// ---- tb/tb.sv ----
// Bench: host and flash ends joined on one link, a second flash end on a raw link.
// Assumes shortened array timing so every operation ends within a few hundred cycles.
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH %0t got %0h exp %0h", $time, (got), (exp)); end end
module tb;
    localparam int unsigned XFR = 20;
    localparam int unsigned CMP = 20;
    localparam int unsigned EP = 50;
    localparam int LIMIT = 90000;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic page_size_512 = 1'b1;
    logic arr_mismatch = 1'b0;
    logic cmd_valid = 1'b0;
    logic [19:0] cmd_data = 20'h00000;
    logic arr_req;
    sfa_pkg::sfa_arr_op_t arr_op;
    logic [11:0] arr_page;
    logic arr_buf2;
    logic dev_busy;
    logic arr_req_b;
    sfa_pkg::sfa_arr_op_t arr_op_b;
    logic [11:0] arr_page_b;
    logic busy_b;
    logic cmd_ready;
    logic rd_valid;
    logic [7:0] rd_data;
    logic [7:0] status;
    logic host_busy;
    logic exp_comp = 1'b0;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;

    sfa_if lnk();
    sfa_if lnk_b();
    always #25 clk_sys = ~clk_sys;

    sfa_dev #(.XFR_CYCLES(XFR), .CMP_CYCLES(CMP), .EP_CYCLES(EP)) sfa_dev_inst (
        .clk_sys(clk_sys), .resetn(resetn), .spi(lnk.dev), .page_size_512(page_size_512),
        .arr_mismatch(arr_mismatch), .arr_req(arr_req), .arr_op(arr_op),
        .arr_page(arr_page), .arr_buf2(arr_buf2), .busy(dev_busy));
    // Second end faces the bench directly so misuse of the link can be driven
    sfa_dev #(.XFR_CYCLES(XFR), .CMP_CYCLES(CMP), .EP_CYCLES(EP)) sfa_dev_inst_b (
        .clk_sys(clk_sys), .resetn(resetn), .spi(lnk_b.dev), .page_size_512(page_size_512),
        .arr_mismatch(arr_mismatch), .arr_req(arr_req_b), .arr_op(arr_op_b),
        .arr_page(arr_page_b), .arr_buf2(), .busy(busy_b));
    sfa_host sfa_host_inst (
        .clk_sys(clk_sys), .resetn(resetn), .spi(lnk.host), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_data(cmd_data), .rd_valid(rd_valid), .rd_data(rd_data),
        .status(status), .busy(host_busy));
    sfa_properties sfa_properties_inst (
        .clk_sys(clk_sys), .resetn(resetn), .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si),
        .so_out(lnk.so_out), .so_oe(lnk.so_oe), .so_line(lnk.so_line));

    task automatic close_out;
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            close_out();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic push(input logic [7:0] op, input logic [11:0] pg);
        int i;
        cmd_valid = 1'b1;
        cmd_data = {op, pg};
        for (i = 0; i < 50 && cmd_ready !== 1'b1; i++) tick(1);
        tick(1);
        cmd_valid = 1'b0;
    endtask

    task automatic wait_idle;
        int i;
        tick(3);
        for (i = 0; i < 9000 && host_busy !== 1'b0; i++) tick(1);
        tick(8);
        for (i = 0; i < 300 && dev_busy !== 1'b0; i++) tick(1);
    endtask

    task automatic t_sec;
        int i;
        int k;
        k = 0;
        push(sfa_pkg::OP_SEC_RD, 12'h000);
        for (i = 0; i < 30000 && k < 128; i++) begin
            if (rd_valid === 1'b1) begin
                `CHK(rd_data, 8'(k * 32'h3B) ^ 8'hA5)
                k++;
            end
            tick(1);
        end
        `CHK(k, 128)
        wait_idle();
    endtask

    // One command, its array request and busy length, then a status poll
    task automatic t_op(input logic [7:0] op, input logic [11:0] pg, input logic p512,
                        input logic mis, input sfa_pkg::sfa_arr_op_t eop, input logic eb2,
                        input int elen);
        int i;
        int n;
        page_size_512 = p512;
        arr_mismatch = mis;
        push(op, pg);
        for (i = 0; i < 4000 && arr_req !== 1'b1; i++) tick(1);
        `CHK(arr_req, 1'b1)
        `CHK(arr_op, eop)
        `CHK(arr_page, pg)
        `CHK(arr_buf2, eb2)
        n = 0;
        for (i = 0; i < 300 && dev_busy === 1'b1; i++) begin
            n++;
            tick(1);
        end
        `CHK(n >= elen - 1 && n <= elen + 1, 1'b1)
        if (eop == sfa_pkg::ARR_CMP) begin
            exp_comp = mis;
        end
        push(sfa_pkg::OP_STAT, 12'h000);
        wait_idle();
        `CHK(status[sfa_pkg::ST_RDY], 1'b1)
        `CHK(status[sfa_pkg::ST_COMP], exp_comp)
        `CHK(status[sfa_pkg::ST_P512], p512)
    endtask

    // Fill the command queue until it refuses, then let it drain
    task automatic t_fifo;
        int i;
        int acc;
        acc = 0;
        cmd_data = {sfa_pkg::OP_STAT, 12'h000};
        cmd_valid = 1'b1;
        for (i = 0; i < 12 && cmd_ready === 1'b1; i++) begin
            tick(1);
            acc++;
        end
        cmd_valid = 1'b0;
        `CHK(acc >= 8 && acc <= 9, 1'b1)
        `CHK(cmd_ready, 1'b0)
        wait_idle();
        `CHK(cmd_ready, 1'b1)
        `CHK(status[sfa_pkg::ST_RDY], 1'b1)
    endtask

    task automatic raw_frame(input logic [39:0] v, input int n);
        int i;
        lnk_b.cs_n = 1'b0;
        for (i = 0; i < n; i++) begin
            lnk_b.si = v[39 - i];
            tick(4);
            lnk_b.sck = 1'b1;
            tick(4);
            lnk_b.sck = 1'b0;
        end
        tick(4);
        lnk_b.cs_n = 1'b1;
        lnk_b.si = 1'b0;
    endtask

    task automatic t_raw;
        int i;
        logic seen;
        page_size_512 = 1'b1;
        raw_frame({sfa_pkg::OP_RW_B1, 24'h001200, 8'h5A}, 40);
        for (i = 0; i < 100 && arr_req_b !== 1'b1; i++) tick(1);
        `CHK(arr_req_b, 1'b1)
        `CHK(arr_op_b, sfa_pkg::ARR_RMW)
        `CHK(arr_page_b, 12'h009)
        tick(2);
        for (i = 0; i < 300 && busy_b !== 1'b0; i++) tick(1);
        // A header one bit short must start nothing
        raw_frame({sfa_pkg::OP_XFER_B1, 24'h000200, 8'h00}, 31);
        seen = 1'b0;
        for (i = 0; i < 200; i++) begin
            if (arr_req_b === 1'b1) seen = 1'b1;
            tick(1);
        end
        `CHK(seen, 1'b0)
    endtask

    initial begin
        lnk_b.cs_n = 1'b1;
        lnk_b.sck = 1'b0;
        lnk_b.si = 1'b0;
        tick(2);
        resetn = 1'b1;
        tick(3);
        t_sec();
        t_op(sfa_pkg::OP_XFER_B1, 12'hFFF, 1'b1, 1'b0, sfa_pkg::ARR_XFER, 1'b0, XFR);
        t_op(sfa_pkg::OP_XFER_B2, 12'h001, 1'b0, 1'b0, sfa_pkg::ARR_XFER, 1'b1, XFR);
        t_op(sfa_pkg::OP_CMP_B1, 12'h800, 1'b1, 1'b1, sfa_pkg::ARR_CMP, 1'b0, CMP);
        t_op(sfa_pkg::OP_CMP_B2, 12'h7FE, 1'b0, 1'b0, sfa_pkg::ARR_CMP, 1'b1, CMP);
        t_op(sfa_pkg::OP_RW_B1, 12'hA5C, 1'b1, 1'b1, sfa_pkg::ARR_REWRITE, 1'b0, XFR + EP);
        t_op(sfa_pkg::OP_RW_B2, 12'h000, 1'b0, 1'b1, sfa_pkg::ARR_REWRITE, 1'b1, XFR + EP);
        t_op(sfa_pkg::OP_CMP_B1, 12'h123, 1'b1, 1'b1, sfa_pkg::ARR_CMP, 1'b0, CMP);
        t_fifo();
        t_raw();
        close_out();
    end
endmodule
